// *** verilog/reset_cause_pkg.sv ***
package reset_cause_pkg;

  // Clock and reset hold timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int HOLD_TIME_NS  = 40;
  localparam int HOLD_CYCLES   = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W    = $clog2(HOLD_CYCLES + 1);

  // Register indices; byte address is four times the index
  localparam logic [9:0] STATUS_IDX     = 10'h003;
  localparam logic [9:0] INTERRUPT_CONTROL_REG_IDX     = 10'h00b;
  localparam logic [9:0] PERIPHERAL_IRQ_FLAGS_IDX       = 10'h00c;
  localparam logic [9:0] COMPARATOR_CONFIG_IDX      = 10'h01f;
  localparam logic [9:0] OPTION_IDX     = 10'h081;
  localparam logic [9:0] PORTA_DIR_IDX  = 10'h085;
  localparam logic [9:0] PORTB_DIR_IDX  = 10'h086;
  localparam logic [9:0] POWER_CONTROL_FLAGS_IDX       = 10'h08e;
  localparam logic [9:0] VOLTAGE_REFERENCE_CONFIG_IDX      = 10'h09f;
  localparam logic [9:0] IRQ_STATUS_IDX = 10'h0c0;
  localparam logic [9:0] IRQ_MASK_IDX   = 10'h0c1;
  localparam logic [9:0] CONTROL_IDX    = 10'h0c2;

  // Field positions
  localparam int TO_BIT       = 4;
  localparam int PD_BIT       = 3;
  localparam int POR_BIT      = 1;
  localparam int BOR_BIT      = 0;
  localparam int GIE_BIT      = 7;
  localparam int CMP_FLAG_BIT = 6;
  localparam int CTRL_SLEEP   = 0;
  localparam int CTRL_BOR_EN  = 1;

  // Values loaded by a reset, plus write mask, interrupt vector and cause count
  localparam logic [7:0]  OPTION_RESET    = 8'hff;
  localparam logic [4:0]  PORTA_DIR_RESET = 5'h1f;
  localparam logic [7:0]  PORTB_DIR_RESET = 8'hff;
  localparam logic [5:0]  COMPARATOR_CONFIG_RESET     = 6'h00;
  localparam logic [7:0]  VOLTAGE_REFERENCE_CONFIG_RESET     = 8'h00;
  localparam logic [7:0]  VOLTAGE_REFERENCE_CONFIG_MASK      = 8'hef;
  localparam logic [7:0]  STATUS_POR      = 8'h18;
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;
  localparam logic [15:0] IRQ_VECTOR      = 16'h0004;
  localparam int          NUM_CAUSES      = 7;

  typedef enum logic [2:0] {
    CAUSE_POR,
    CAUSE_PIN_RUN,
    CAUSE_PIN_SLEEP,
    CAUSE_WDT_RUN,
    CAUSE_WDT_WAKE,
    CAUSE_BOR,
    CAUSE_IRQ_WAKE
  } cause_type;

  typedef enum logic [1:0] {
    SEQ_HOLD,
    SEQ_RUN,
    SEQ_SLEEP,
    SEQ_VECTOR
  } seq_type;

endpackage

// *** verilog/cause_if.sv ***
`timescale 1ns/10ps
interface cause_if #(
  parameter int PC_WIDTH = 13
);
  reset_cause_pkg::cause_type cause;
  logic [7:0]                 status_old;
  logic [1:0]                 power_control_flags_old;
  logic [7:0]                 interrupt_control_reg_old;
  logic [PC_WIDTH-1:0]        pc_old;
  logic [7:0]                 status_new;
  logic [1:0]                 power_control_flags_new;
  logic [PC_WIDTH-1:0]        pc_new;
  logic                       is_wake;
  logic                       vector_after;

  modport requester (
    output cause, status_old, power_control_flags_old, interrupt_control_reg_old, pc_old,
    input  status_new, power_control_flags_new, pc_new, is_wake, vector_after
  );

  modport encoder (
    input  cause, status_old, power_control_flags_old, interrupt_control_reg_old, pc_old,
    output status_new, power_control_flags_new, pc_new, is_wake, vector_after
  );
endinterface

// *** verilog/reset_cause_encoder.sv ***
`timescale 1ns/10ps
module reset_cause_encoder #(
  parameter int PC_WIDTH = 13
) (
  cause_if.encoder link
);

  // Flag, counter and vector values for the pending cause
  always_comb begin
    link.status_new   = link.status_old;
    link.power_control_flags_new     = link.power_control_flags_old;
    link.pc_new       = reset_cause_pkg::RESET_VECTOR[PC_WIDTH-1:0];
    link.is_wake      = 1'b0;
    link.vector_after = 1'b0;
    unique case (link.cause)
      reset_cause_pkg::CAUSE_POR: begin
        link.status_new = reset_cause_pkg::STATUS_POR;
        link.power_control_flags_new   = 2'b00;
      end
      reset_cause_pkg::CAUSE_PIN_RUN: begin
        link.status_new[7:5] = 3'b000;
      end
      reset_cause_pkg::CAUSE_PIN_SLEEP: begin
        link.status_new[7:5]                     = 3'b000;
        link.status_new[reset_cause_pkg::TO_BIT] = 1'b1;
        link.status_new[reset_cause_pkg::PD_BIT] = 1'b0;
      end
      reset_cause_pkg::CAUSE_WDT_RUN: begin
        link.status_new[7:5]                     = 3'b000;
        link.status_new[reset_cause_pkg::TO_BIT] = 1'b0;
      end
      reset_cause_pkg::CAUSE_WDT_WAKE: begin
        link.status_new[reset_cause_pkg::TO_BIT] = 1'b0;
        link.status_new[reset_cause_pkg::PD_BIT] = 1'b0;
        link.pc_new  = link.pc_old + 1'b1;
        link.is_wake = 1'b1;
      end
      reset_cause_pkg::CAUSE_BOR: begin
        link.status_new[7:5]                   = 3'b000;
        link.power_control_flags_new[reset_cause_pkg::BOR_BIT] = 1'b0;
      end
      reset_cause_pkg::CAUSE_IRQ_WAKE: begin
        link.status_new[reset_cause_pkg::TO_BIT] = 1'b1;
        link.status_new[reset_cause_pkg::PD_BIT] = 1'b0;
        link.pc_new       = link.pc_old + 1'b1;
        link.is_wake      = 1'b1;
        link.vector_after = link.interrupt_control_reg_old[reset_cause_pkg::GIE_BIT];
      end
    endcase
  end

endmodule

// *** verilog/reset_cause_and_init_state.sv ***
`timescale 1ns/10ps
// Summary of operation
// - A power-on reset leaves the time-out flag set.
// - A power-on reset leaves the power-down flag set.
// - A pin reset while running loads address zero and clears status bits 7..5 only.
// - A pin reset while asleep loads address zero, sets time-out and clears power-down.
// - An interrupt wake-up resumes at the next address, sets time-out, clears power-down.
// - With interrupts globally enabled, an interrupt wake-up runs one instruction then jumps to 0x004.
// - A watchdog reset clears time-out at address zero; a watchdog wake-up clears both.
// - A brown-out reset loads address zero, clears the brown-out flag, keeps the other.
// - The four cause flags tell the resets apart, except a pin reset while running, which leaves all four unchanged.
// - Non power-on resets clear status bits 7..5, set time-out and power-down by cause.
// - Power-on loads status 0001 1xxx and clears the power-on flag.
// - Unused power-control bits 7..2 read as zero.
// - Wake-ups keep the special registers but merge wake flags; resets load fixed values.
// - The brown-out flag may be anything while the brown-out detector is disabled.
module reset_cause_and_init_state #(
  parameter int PC_WIDTH = 13
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                external_reset_pin_n,
  input  wire logic                watchdog_timer,
  input  wire logic                brownout_detect,
  input  wire logic                irq_wake,
  input  wire logic [2:0]          wake_int_flags,
  input  wire logic                wake_cmp_flag,
  input  wire logic [PC_WIDTH-1:0] core_pc,
  input  wire logic                instr_done,
  output logic                     core_hold,
  output logic                     pc_load,
  output logic      [PC_WIDTH-1:0] pc_value,
  output logic                     asleep,
  output logic                     global_irq_enable,
  output logic      [4:0]          port_a_direction,
  output logic      [7:0]          port_b_direction,
  output logic                     irq
);

  generate
    if (PC_WIDTH < 3 || PC_WIDTH > 16) begin : g_bad_width
      $error("PC_WIDTH must lie between 3 and 16");
    end
  endgenerate

  typedef struct packed {
    reset_cause_pkg::seq_type               state;
    reset_cause_pkg::cause_type             cause;
    logic [reset_cause_pkg::HOLD_CNT_W-1:0] hold_cnt;
    logic                                   core_hold;
    logic                                   pc_load;
    logic [PC_WIDTH-1:0]                    pc_value;
    logic                                   asleep;
    logic [7:0]                             status;
    logic [1:0]                             power_control_flags;
    logic [7:0]                             interrupt_control_reg;
    logic                                   cmp_flag;
    logic [5:0]                             comparator_config;
    logic [7:0]                             option;
    logic [4:0]                             dir_a;
    logic [7:0]                             dir_b;
    logic [7:0]                             voltage_reference_config;
    logic [reset_cause_pkg::NUM_CAUSES-1:0] irq_status;
    logic [reset_cause_pkg::NUM_CAUSES-1:0] irq_mask;
    logic                                   bor_en;
    logic                                   pready;
    logic                                   pslverr;
    logic [31:0]                            prdata;
    logic                                   irq;
  } state_type;

  localparam state_type RESET_STATE = '{
    state:    reset_cause_pkg::SEQ_HOLD,
    cause:    reset_cause_pkg::CAUSE_POR,
    hold_cnt: reset_cause_pkg::HOLD_CNT_W'(reset_cause_pkg::HOLD_CYCLES - 1),
    core_hold: 1'b1,
    option:   reset_cause_pkg::OPTION_RESET,
    dir_a:    reset_cause_pkg::PORTA_DIR_RESET,
    dir_b:    reset_cause_pkg::PORTB_DIR_RESET,
    bor_en:   1'b1,
    default:  '0
  };

  state_type s_reg;
  state_type s_next;
  logic [9:0] idx;
  logic       setup;
  logic       access;

  cause_if #(.PC_WIDTH(PC_WIDTH)) link ();

  reset_cause_encoder #(.PC_WIDTH(PC_WIDTH)) encoder_inst (
    .link (link.encoder)
  );

  // Encoder sees the pending cause and the current register values
  assign link.cause      = s_reg.cause;
  assign link.status_old = s_reg.status;
  assign link.power_control_flags_old   = s_reg.power_control_flags;
  assign link.interrupt_control_reg_old = s_reg.interrupt_control_reg;
  assign link.pc_old     = core_pc;

  assign idx    = paddr[11:2];
  assign setup  = psel && !penable;
  assign access = psel && penable && s_reg.pready;

  // Known register address check
  function automatic logic addr_mapped(input logic [11:0] a);
    logic [9:0] i;
    i = a[11:2];
    return (a[1:0] == 2'b00) &&
           (i == reset_cause_pkg::STATUS_IDX || i == reset_cause_pkg::INTERRUPT_CONTROL_REG_IDX ||
            i == reset_cause_pkg::PERIPHERAL_IRQ_FLAGS_IDX || i == reset_cause_pkg::COMPARATOR_CONFIG_IDX ||
            i == reset_cause_pkg::OPTION_IDX || i == reset_cause_pkg::PORTA_DIR_IDX ||
            i == reset_cause_pkg::PORTB_DIR_IDX || i == reset_cause_pkg::POWER_CONTROL_FLAGS_IDX ||
            i == reset_cause_pkg::VOLTAGE_REFERENCE_CONFIG_IDX || i == reset_cause_pkg::IRQ_STATUS_IDX ||
            i == reset_cause_pkg::IRQ_MASK_IDX || i == reset_cause_pkg::CONTROL_IDX);
  endfunction

  // Read data for one register; unused bits are zero
  function automatic logic [31:0] read_word(input state_type s, input logic [9:0] i);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (i)
      reset_cause_pkg::STATUS_IDX:     d[7:0] = s.status;
      reset_cause_pkg::POWER_CONTROL_FLAGS_IDX:       d[1:0] = s.power_control_flags;
      reset_cause_pkg::INTERRUPT_CONTROL_REG_IDX:     d[7:0] = s.interrupt_control_reg;
      reset_cause_pkg::PERIPHERAL_IRQ_FLAGS_IDX:       d[reset_cause_pkg::CMP_FLAG_BIT] = s.cmp_flag;
      reset_cause_pkg::COMPARATOR_CONFIG_IDX:      d[5:0] = s.comparator_config;
      reset_cause_pkg::OPTION_IDX:     d[7:0] = s.option;
      reset_cause_pkg::PORTA_DIR_IDX:  d[4:0] = s.dir_a;
      reset_cause_pkg::PORTB_DIR_IDX:  d[7:0] = s.dir_b;
      reset_cause_pkg::VOLTAGE_REFERENCE_CONFIG_IDX:      d[7:0] = s.voltage_reference_config;
      reset_cause_pkg::IRQ_STATUS_IDX: d[6:0] = s.irq_status;
      reset_cause_pkg::IRQ_MASK_IDX:   d[6:0] = s.irq_mask;
      reset_cause_pkg::CONTROL_IDX:    d[reset_cause_pkg::CTRL_BOR_EN] = s.bor_en;
      default:                         d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // Begin a hold sequence for a new cause
  function automatic state_type start_hold(input state_type s,
                                           input reset_cause_pkg::cause_type c);
    state_type t;
    t           = s;
    t.state     = reset_cause_pkg::SEQ_HOLD;
    t.cause     = c;
    t.hold_cnt  = reset_cause_pkg::HOLD_CNT_W'(reset_cause_pkg::HOLD_CYCLES - 1);
    t.core_hold = 1'b1;
    t.asleep    = 1'b0;
    return t;
  endfunction

  // Next state: bus access, sequencer, interrupt
  always_comb begin
    logic sleep_req;
    logic bor_hit;
    sleep_req = 1'b0;
    s_next = s_reg;
    s_next.pc_load = 1'b0;
    bor_hit = brownout_detect && s_reg.bor_en;

    // APB answer one cycle after setup
    s_next.pready  = setup;
    s_next.pslverr = setup && !addr_mapped(paddr);
    if (setup) begin
      s_next.prdata = pwrite ? 32'h0000_0000 : read_word(s_reg, idx);
    end
    if (access && !s_reg.pslverr && pwrite) begin
      unique case (idx)
        reset_cause_pkg::STATUS_IDX: begin
          s_next.status[7:5] = pwdata[7:5];
          s_next.status[2:0] = pwdata[2:0];
        end
        reset_cause_pkg::POWER_CONTROL_FLAGS_IDX:      s_next.power_control_flags   = pwdata[1:0];
        reset_cause_pkg::INTERRUPT_CONTROL_REG_IDX:    s_next.interrupt_control_reg = pwdata[7:0];
        reset_cause_pkg::PERIPHERAL_IRQ_FLAGS_IDX:      s_next.cmp_flag = pwdata[reset_cause_pkg::CMP_FLAG_BIT];
        reset_cause_pkg::COMPARATOR_CONFIG_IDX:     s_next.comparator_config  = pwdata[5:0];
        reset_cause_pkg::OPTION_IDX:    s_next.option = pwdata[7:0];
        reset_cause_pkg::PORTA_DIR_IDX: s_next.dir_a  = pwdata[4:0];
        reset_cause_pkg::PORTB_DIR_IDX: s_next.dir_b  = pwdata[7:0];
        reset_cause_pkg::VOLTAGE_REFERENCE_CONFIG_IDX:     s_next.voltage_reference_config  = pwdata[7:0] & reset_cause_pkg::VOLTAGE_REFERENCE_CONFIG_MASK;
        reset_cause_pkg::IRQ_MASK_IDX:  s_next.irq_mask = pwdata[6:0];
        reset_cause_pkg::CONTROL_IDX: begin
          s_next.bor_en = pwdata[reset_cause_pkg::CTRL_BOR_EN];
          sleep_req     = pwdata[reset_cause_pkg::CTRL_SLEEP];
        end
        default: begin
        end
      endcase
    end
    // Read clears only the bits that were returned
    if (access && !pwrite && idx == reset_cause_pkg::IRQ_STATUS_IDX && !s_reg.pslverr) begin
      s_next.irq_status = s_reg.irq_status & ~s_reg.prdata[6:0];
    end

    // Reset and wake sequencer
    unique case (s_reg.state)
      reset_cause_pkg::SEQ_HOLD: begin
        if (bor_hit) begin
          s_next = start_hold(s_next, reset_cause_pkg::CAUSE_BOR);
        end else if (!external_reset_pin_n) begin
          s_next = start_hold(s_next, s_reg.cause);
        end else if (s_reg.hold_cnt != '0) begin
          s_next.hold_cnt = s_reg.hold_cnt - 1'b1;
        end else begin
          s_next.status    = link.status_new;
          s_next.power_control_flags      = link.power_control_flags_new;
          s_next.pc_value  = link.pc_new;
          s_next.pc_load   = 1'b1;
          s_next.core_hold = 1'b0;
          s_next.irq_status[s_reg.cause] = 1'b1;
          s_next.state = link.vector_after ? reset_cause_pkg::SEQ_VECTOR
                                           : reset_cause_pkg::SEQ_RUN;
          if (link.is_wake) begin
            s_next.interrupt_control_reg[2:0] = s_next.interrupt_control_reg[2:0] | wake_int_flags;
            s_next.cmp_flag    = s_next.cmp_flag | wake_cmp_flag;
          end else begin
            s_next.option   = reset_cause_pkg::OPTION_RESET;
            s_next.dir_a    = reset_cause_pkg::PORTA_DIR_RESET;
            s_next.dir_b    = reset_cause_pkg::PORTB_DIR_RESET;
            s_next.comparator_config    = reset_cause_pkg::COMPARATOR_CONFIG_RESET;
            s_next.voltage_reference_config    = reset_cause_pkg::VOLTAGE_REFERENCE_CONFIG_RESET;
            s_next.cmp_flag = 1'b0;
            s_next.interrupt_control_reg[7:1] = 7'h00;
            if (s_reg.cause == reset_cause_pkg::CAUSE_POR) begin
              s_next.interrupt_control_reg[0] = 1'b0;
            end
          end
        end
      end
      reset_cause_pkg::SEQ_RUN, reset_cause_pkg::SEQ_VECTOR: begin
        if (bor_hit) begin
          s_next = start_hold(s_next, reset_cause_pkg::CAUSE_BOR);
        end else if (!external_reset_pin_n) begin
          s_next = start_hold(s_next, reset_cause_pkg::CAUSE_PIN_RUN);
        end else if (watchdog_timer) begin
          s_next = start_hold(s_next, reset_cause_pkg::CAUSE_WDT_RUN);
        end else if (s_reg.state == reset_cause_pkg::SEQ_VECTOR) begin
          if (instr_done) begin
            s_next.pc_value = reset_cause_pkg::IRQ_VECTOR[PC_WIDTH-1:0];
            s_next.pc_load  = 1'b1;
            s_next.interrupt_control_reg[reset_cause_pkg::GIE_BIT] = 1'b0;
            s_next.state    = reset_cause_pkg::SEQ_RUN;
          end
        end else if (sleep_req) begin
          s_next.state  = reset_cause_pkg::SEQ_SLEEP;
          s_next.asleep = 1'b1;
        end
      end
      reset_cause_pkg::SEQ_SLEEP: begin
        if (bor_hit) begin
          s_next = start_hold(s_next, reset_cause_pkg::CAUSE_BOR);
        end else if (!external_reset_pin_n) begin
          s_next = start_hold(s_next, reset_cause_pkg::CAUSE_PIN_SLEEP);
        end else if (watchdog_timer) begin
          s_next = start_hold(s_next, reset_cause_pkg::CAUSE_WDT_WAKE);
        end else if (irq_wake) begin
          s_next = start_hold(s_next, reset_cause_pkg::CAUSE_IRQ_WAKE);
        end
      end
    endcase

    // Level interrupt from unmasked sticky bits
    s_next.irq = |(s_next.irq_status & s_next.irq_mask);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign prdata            = s_reg.prdata;
  assign pready            = s_reg.pready;
  assign pslverr           = s_reg.pslverr;
  assign core_hold         = s_reg.core_hold;
  assign pc_load           = s_reg.pc_load;
  assign pc_value          = s_reg.pc_value;
  assign asleep            = s_reg.asleep;
  assign global_irq_enable = s_reg.interrupt_control_reg[reset_cause_pkg::GIE_BIT];
  assign port_a_direction  = s_reg.dir_a;
  assign port_b_direction  = s_reg.dir_b;
  assign irq               = s_reg.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence done_by(reset_cause_pkg::cause_type c);
    $fell(s_reg.core_hold) && s_reg.cause == c;
  endsequence

  sequence power_control_flags_read;
    psel && !penable && !pwrite && paddr[11:2] == reset_cause_pkg::POWER_CONTROL_FLAGS_IDX;
  endsequence

  hold_end_load_a: assert property (
    s_reg.core_hold && s_reg.hold_cnt == '0 && brownout_detect == 1'b0 &&
    external_reset_pin_n |=> !s_reg.core_hold && s_reg.pc_load)
    else $error("hold did not end with an address load");
  por_flags_a: assert property (
    done_by(reset_cause_pkg::CAUSE_POR) |-> s_reg.status[reset_cause_pkg::TO_BIT] &&
    s_reg.status[reset_cause_pkg::PD_BIT] && s_reg.status[7:5] == 3'b000 &&
    !s_reg.power_control_flags[reset_cause_pkg::POR_BIT])
    else $error("power-on flags wrong");
  pin_run_a: assert property (
    done_by(reset_cause_pkg::CAUSE_PIN_RUN) |-> s_reg.status[7:5] == 3'b000 &&
    s_reg.pc_value == '0 && s_reg.pc_load)
    else $error("pin reset while running wrong");
  pin_sleep_a: assert property (
    done_by(reset_cause_pkg::CAUSE_PIN_SLEEP) |-> s_reg.status[reset_cause_pkg::TO_BIT] &&
    !s_reg.status[reset_cause_pkg::PD_BIT] && s_reg.pc_value == '0)
    else $error("pin reset while asleep wrong");
  irq_wake_pc_a: assert property (
    done_by(reset_cause_pkg::CAUSE_IRQ_WAKE) |-> s_reg.pc_value == $past(core_pc) + 1'b1 &&
    s_reg.status[reset_cause_pkg::TO_BIT] && !s_reg.status[reset_cause_pkg::PD_BIT])
    else $error("interrupt wake-up address or flags wrong");
  vector_jump_a: assert property (
    s_reg.state == reset_cause_pkg::SEQ_VECTOR && instr_done && external_reset_pin_n &&
    !watchdog_timer && !(brownout_detect && s_reg.bor_en) |=> s_reg.pc_load &&
    s_reg.pc_value == reset_cause_pkg::IRQ_VECTOR[PC_WIDTH-1:0] && !global_irq_enable)
    else $error("interrupt vector jump missing");
  wdt_wake_a: assert property (
    done_by(reset_cause_pkg::CAUSE_WDT_WAKE) |-> !s_reg.status[reset_cause_pkg::TO_BIT] &&
    !s_reg.status[reset_cause_pkg::PD_BIT] && s_reg.pc_value == $past(core_pc) + 1'b1)
    else $error("watchdog wake-up wrong");
  bor_flag_a: assert property (
    done_by(reset_cause_pkg::CAUSE_BOR) |-> !s_reg.power_control_flags[reset_cause_pkg::BOR_BIT] &&
    s_reg.power_control_flags[reset_cause_pkg::POR_BIT] == $past(s_reg.power_control_flags[reset_cause_pkg::POR_BIT]))
    else $error("brown-out flags wrong");
  power_control_flags_upper_a: assert property (
    power_control_flags_read |=> pready && prdata[31:2] == 30'h0)
    else $error("power-control upper bits not zero");
  wake_keeps_a: assert property (
    done_by(reset_cause_pkg::CAUSE_WDT_WAKE) |-> $stable(s_reg.option) &&
    $stable(s_reg.dir_b) && $stable(s_reg.voltage_reference_config))
    else $error("wake-up changed special registers");

endmodule

// *** bench/tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, asleep;
  logic        external_reset_pin_n, watchdog_timer, brownout_detect, irq_wake, instr_done;
  logic        core_hold, pc_load, global_irq_enable, wake_cmp_flag;
  logic [2:0]  wake_int_flags;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] core_pc, pc_value, pe;
  logic [4:0]  port_a_direction;
  logic [7:0]  port_b_direction;
  logic [15:0] rnd;
  logic [32:0] rq[$], ex;
  logic [12:0] pq[$];
  int          n_errors, checked;

  reset_cause_and_init_state reset_cause_and_init_state_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_reset_pin_n, .watchdog_timer, .brownout_detect, .irq_wake, .wake_int_flags,
    .wake_cmp_flag, .core_pc, .instr_done, .core_hold, .pc_load, .pc_value, .asleep,
    .global_irq_enable, .port_a_direction, .port_b_direction, .irq);

  // Clock
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Bus master, reads noted in the queue
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) rq.push_back(e);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  task wload;
    do @(posedge pclk); while (pc_load !== 1'b1);
  endtask

  // Status, power flags and cause bit; read clears irq
  task regs(input logic [7:0] st, input logic [7:0] pc, input logic [7:0] iq);
    @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    apb(0, 12'h00c, 0, {25'h0, st});
    apb(0, 12'h238, 0, {25'h0, pc});
    apb(0, 12'h300, 0, {25'h0, iq});
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b0, irq)
  endtask

  task sleep_in;
    apb(1, 12'h308, 32'h3, 0);
    repeat (3) @(posedge pclk);
    `CHK("asleep", 1'b1, asleep)
  endtask

  task end_sim;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Monitor compares oldest notes
  always @(posedge pclk) begin
    if (pready === 1'b1 && psel && !pwrite) begin
      ex = rq.pop_front();
      `CHK("read", ex, {pslverr, prdata})
    end
    if (pc_load === 1'b1) begin
      pe = pq.pop_front();
      `CHK("pc_value", pe, pc_value)
    end
  end

  // Main sequence
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    external_reset_pin_n = 1; watchdog_timer = 0; brownout_detect = 0; irq_wake = 0;
    instr_done = 0; core_pc = 0; wake_int_flags = 0; wake_cmp_flag = 0;
    n_errors = 0; checked = 0; rnd = 16'd48426;
    pq.push_back(13'h0);
    repeat (4) @(posedge pclk);
    rnd = lfsr(rnd);
    presetn <= 1; core_pc <= rnd[12:0]; wake_int_flags <= rnd[2:0]; wake_cmp_flag <= rnd[3];
    wload;
    apb(1, 12'h304, 32'h7f, 0);
    regs(8'h18, 8'h00, 8'h01);
    `CHK("port_a_direction", 5'h1f, port_a_direction)
    `CHK("port_b_direction", 8'hff, port_b_direction)
    rnd = lfsr(rnd);
    apb(1, 12'h238, {rnd, 16'h0003}, 0);
    apb(0, 12'h238, 0, 33'h3);
    apb(0, 12'h3fc, 0, {1'b1, 32'h0});
    $display("test power-on done");
    pq.push_back(13'h0);
    external_reset_pin_n <= 0;
    repeat (3) @(posedge pclk);
    external_reset_pin_n <= 1;
    wload;
    regs(8'h18, 8'h03, 8'h02);
    pq.push_back(13'h0);
    @(posedge pclk) watchdog_timer <= 1;
    @(posedge pclk) watchdog_timer <= 0;
    wload;
    regs(8'h08, 8'h03, 8'h08);
    // Random direction word and wake inputs for the watchdog wake
    rnd = lfsr(rnd);
    apb(1, 12'h218, {24'h0, rnd[15:8]}, 0);
    core_pc <= rnd[12:0];
    wake_int_flags <= rnd[2:0];
    wake_cmp_flag <= rnd[3];
    sleep_in;
    pq.push_back(rnd[12:0] + 13'h1);
    @(posedge pclk) watchdog_timer <= 1;
    @(posedge pclk) watchdog_timer <= 0;
    wload;
    regs(8'h00, 8'h03, 8'h10);
    apb(0, 12'h02c, 0, {30'h0, rnd[2:0]});
    apb(0, 12'h030, 0, {26'h0, rnd[3], 6'h0});
    `CHK("port_b_direction", rnd[15:8], port_b_direction)
    $display("test pin and watchdog done");
    sleep_in;
    pq.push_back(13'h0);
    external_reset_pin_n <= 0;
    repeat (3) @(posedge pclk);
    external_reset_pin_n <= 1;
    wload;
    regs(8'h10, 8'h03, 8'h04);
    `CHK("port_b_direction", 8'hff, port_b_direction)
    `CHK("port_a_direction", 5'h1f, port_a_direction)
    apb(1, 12'h02c, 32'h80, 0);
    rnd = lfsr(rnd);
    core_pc <= rnd[12:0];
    sleep_in;
    pq.push_back(rnd[12:0] + 13'h1);
    pq.push_back(13'h4);
    @(posedge pclk) irq_wake <= 1;
    @(posedge pclk) irq_wake <= 0;
    wload;
    regs(8'h10, 8'h03, 8'h40);
    instr_done <= 1;
    @(posedge pclk) instr_done <= 0;
    wload;
    `CHK("irq_enable", 1'b0, global_irq_enable)
    $display("test sleep wakes done");
    pq.push_back(13'h0);
    brownout_detect <= 1;
    repeat (3) @(posedge pclk);
    brownout_detect <= 0;
    wload;
    regs(8'h10, 8'h02, 8'h20);
    $display("test brown-out done");
    end_sim;
  end

  // Hang guard
  initial begin
    #20000;
    n_errors++;
    end_sim;
  end
endmodule
